//--- rtl/asp_pkg.sv
// package: register map, field layout and timing for the serial port
package asp_pkg;

  // register word offsets (byte address = index * 4, printed offsets odd)
  localparam logic [15:0] SEL_IDX   = 16'h1F90;
  localparam logic [15:0] STAT_IDX  = 16'h1F91;
  localparam logic [15:0] CTL2_IDX  = 16'h1F92;
  localparam logic [15:0] BUF_IDX   = 16'h1F93;
  localparam logic [15:0] CTL1_IDX  = 16'h1F94;
  localparam logic [15:0] TMR_IDX   = 16'h1F95;

  // control one, control two and route select field positions
  localparam int CTL1_TXE   = 7;
  localparam int CTL1_RXE   = 6;
  localparam int CTL1_TRANSMIT_STOP_LENGTH  = 5;
  localparam int CTL1_EVEN  = 4;
  localparam int CTL1_PE    = 3;
  localparam int CTL2_STOPR = 0;
  localparam int SEL_RX     = 0;
  localparam int SEL_TX     = 1;

  // status field positions
  localparam int ST_PARITY_ERROR_FLAG = 7;
  localparam int ST_FRAMING_ERROR_FLAG = 6;
  localparam int ST_OVERRUN_FLAG = 5;
  localparam int ST_RECEIVE_FULL_FLAG = 4;
  localparam int ST_TRANSMIT_END_FLAG = 3;
  localparam int ST_TRANSMIT_EMPTY_FLAG = 2;

  // reset values
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] BUF_RST  = 8'h00;
  localparam logic [7:0] TMR_RST  = 8'h01;

  // baud divider codes and phases per bit
  localparam logic [2:0] BRG_TMR4   = 3'h6;
  localparam logic [3:0] PHASES_MAX = 4'hF;
  localparam logic [3:0] SAMP_A     = 4'h7;
  localparam logic [3:0] SAMP_B     = 4'h8;
  localparam logic [3:0] SAMP_C     = 4'h9;

  // receive and transmit frame phases
  typedef enum logic [2:0] {
    ASP_IDLE, ASP_START, ASP_DATA, ASP_PAR, ASP_STOP1, ASP_STOP2
  } asp_frame_t;

  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [17:0] adr;
    logic [7:0]  dat;
  } asp_wb_req_t;

endpackage

//--- rtl/asp_uart.sv
// async serial port: status, buffers, pin routing, framing, sampling
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
// Functional notes
// - status bits 7..2: parity, framing, overrun, rx full, tx end, empty
// - pin-route bits pick receive and transmit pin choice a or b
// - frame: low start, data, optional parity, one or two high stops
// - baud code 110 uses timer-4 event over compare value, baud is that clock over 16
// - idle receiver samples line per baud tick, low means start
// - each bit sampled at phases 7,8,9 with two-of-three majority
// - buffer write after status read clears empty and starts shifting
// - shift start sets empty flag and pulses transmit interrupt
// - transmit pin high when disabled or until first byte written
// - write without prior status read leaves empty set, no transmit
// - stop received: load buffer, set full flag, pulse rx interrupt
// - frame into full buffer sets overrun, data discarded
// - no reception while overrun flag stays set
// - parity mismatch sets parity error flag
// - stop bit sampled low sets framing error flag
// - buffer read after status read clears four receive flags
// - overrun set after the status read survives that buffer read
// - tx end set when frame done and buffer empty, cleared on start
// - receive disable takes effect when current reception ends
// - transmitter sends one or two stop bits per stop-length bit
// - parity-add enables parity bit, parity-type picks odd or even
// - baud codes: fc/13..fc/416, timer-4 for 110, fc/96 for 111
// - receiver expects one or two stops per receive stop-length bit
// - baud clock and parity shared by transmit and receive
module asp_uart (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [7:0]  dat_i,
  output logic      [7:0]  dat_o,
  output logic             ack_o,
  output logic             err_o,
  // timer and interrupts
  input  wire logic        timer_four_event_i,
  output logic             transmit_interrupt_o,
  output logic             receive_interrupt_o,
  // serial pins
  input  wire logic        receive_pin_a_i,
  input  wire logic        receive_pin_b_i,
  output logic             transmit_pin_a_o,
  output logic             transmit_pin_b_o
);

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  asp_pkg::asp_wb_req_t req;
  logic [7:0]  ctl1;
  logic        receive_stop_length;
  logic [1:0]  pin_route_select;
  logic [7:0]  timer_four_compare_value;
  logic        parity_error_flag, framing_error_flag, overrun_flag;
  logic        receive_full_flag, transmit_end_flag, transmit_empty_flag;
  logic [7:0]  receive_holding_buffer, transmit_holding_buffer;
  logic        stat_seen_rx, stat_seen_tx, ovr_at_stat;
  logic        tx_pending;
  logic [8:0]  div_cnt;
  logic [7:0]  tmr_cnt;
  logic        tick;
  logic [1:0]  rx_meta_a, rx_meta_b;
  logic        rx_line;
  asp_pkg::asp_frame_t rx_st, tx_st;
  logic [3:0]  rx_ph, tx_ph;
  logic [2:0]  rx_bit, tx_bit;
  logic [7:0]  rx_sh, tx_sh;
  logic [2:0]  rx_smp;
  logic        rx_par_bad, rx_stop_bad, tx_line, tx_par;
  logic        acc, rd_stat, rd_buf, wr_buf, wr_ctl1, rx_en_live;
  logic        rx_done, rx_decided;
  logic [8:0]  brg_limit;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, dat: dat_i};

  // word index decode, low two bits are the byte within a word
  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    hit = (a[17:2] == idx);
  endfunction

  // two-of-three vote
  function automatic logic vote(input logic [2:0] s);
    vote = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  assign acc     = req.cyc & req.stb & ~ack_o & ~err_o;
  assign rd_stat = acc & ~req.we & hit(req.adr, asp_pkg::STAT_IDX);
  assign rd_buf  = acc & ~req.we & hit(req.adr, asp_pkg::BUF_IDX);
  assign wr_buf  = acc & req.we & hit(req.adr, asp_pkg::BUF_IDX);
  assign wr_ctl1 = acc & req.we & hit(req.adr, asp_pkg::CTL1_IDX);

  ////////////////////////////////////////////////////////////////////////
  // bus answer: one cycle after the request, unmapped gets err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 8'h00;
    end else begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      if (acc) begin
        if (hit(req.adr, asp_pkg::SEL_IDX) | hit(req.adr, asp_pkg::STAT_IDX) |
            hit(req.adr, asp_pkg::CTL2_IDX) | hit(req.adr, asp_pkg::BUF_IDX) |
            hit(req.adr, asp_pkg::CTL1_IDX) | hit(req.adr, asp_pkg::TMR_IDX))
          ack_o <= 1'b1;
        else
          err_o <= 1'b1;
        dat_o <= 8'h00;
        if (!req.we) begin
          if (hit(req.adr, asp_pkg::STAT_IDX))
            dat_o <= {parity_error_flag, framing_error_flag, overrun_flag,
                      receive_full_flag, transmit_end_flag,
                      transmit_empty_flag, 2'b00};
          if (hit(req.adr, asp_pkg::SEL_IDX))
            dat_o <= {6'h00, pin_route_select};
          if (hit(req.adr, asp_pkg::BUF_IDX))
            dat_o <= receive_holding_buffer;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // writable configuration; control one is write only on the port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl1                     <= asp_pkg::CTL1_RST;
      receive_stop_length      <= 1'b0;
      pin_route_select         <= 2'b00;
      timer_four_compare_value <= asp_pkg::TMR_RST;
    end else if (acc & req.we) begin
      if (wr_ctl1)
        ctl1 <= req.dat;
      if (hit(req.adr, asp_pkg::CTL2_IDX))
        receive_stop_length <= req.dat[asp_pkg::CTL2_STOPR];
      if (hit(req.adr, asp_pkg::SEL_IDX))
        pin_route_select <= req.dat[1:0];
      if (hit(req.adr, asp_pkg::TMR_IDX))
        timer_four_compare_value <= req.dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer clock: phase tick, shared by both directions
  // divider per code
  always_comb begin
    case (ctl1[2:0])
      3'h0:    brg_limit = 9'd13;
      3'h1:    brg_limit = 9'd26;
      3'h2:    brg_limit = 9'd52;
      3'h3:    brg_limit = 9'd104;
      3'h4:    brg_limit = 9'd208;
      3'h5:    brg_limit = 9'd416;
      default: brg_limit = 9'd96;
    endcase
  end

  // one tick for both; tick is a receive phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 9'h000;
      tmr_cnt <= 8'h00;
      tick    <= 1'b0;
    end else if (ctl1[2:0] == asp_pkg::BRG_TMR4) begin
      // timer match divided by compare value gives transfer clock
      div_cnt <= 9'h000;
      tick    <= 1'b0;
      if (timer_four_event_i) begin
        if (tmr_cnt + 8'h01 >= timer_four_compare_value) begin
          tmr_cnt <= 8'h00;
          tick    <= 1'b1;
        end else
          tmr_cnt <= tmr_cnt + 8'h01;
      end
    end else begin
      tmr_cnt <= 8'h00;
      tick    <= (div_cnt == brg_limit - 9'd1);
      div_cnt <= (div_cnt == brg_limit - 9'd1) ? 9'h000 : div_cnt + 9'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, then route select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_a <= 2'b11;
      rx_meta_b <= 2'b11;
    end else begin
      rx_meta_a <= {rx_meta_a[0], receive_pin_a_i};
      rx_meta_b <= {rx_meta_b[0], receive_pin_b_i};
    end
  end
  assign rx_line = pin_route_select[asp_pkg::SEL_RX] ? rx_meta_b[1]
                                                     : rx_meta_a[1];

  ////////////////////////////////////////////////////////////////////////
  // receiver; disable is latched only between frames
  always_ff @(posedge clk_i) begin
    if (rst_i)
      rx_en_live <= 1'b0;
    else if (rx_st == asp_pkg::ASP_IDLE)
      rx_en_live <= ctl1[asp_pkg::CTL1_RXE];
  end

  assign rx_decided = tick & (rx_ph == asp_pkg::SAMP_C);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st       <= asp_pkg::ASP_IDLE;
      rx_ph       <= 4'h0;
      rx_bit      <= 3'h0;
      rx_sh       <= 8'h00;
      rx_smp      <= 3'h0;
      rx_par_bad  <= 1'b0;
      rx_stop_bad <= 1'b0;
      rx_done     <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_ph <= rx_ph + 4'h1;
        if (rx_ph == asp_pkg::SAMP_A || rx_ph == asp_pkg::SAMP_B)
          rx_smp <= {rx_smp[1:0], rx_line};
      end
      case (rx_st)
        asp_pkg::ASP_IDLE: begin
          rx_ph <= 4'h0;
          if (tick & ~rx_line & rx_en_live & ~overrun_flag) begin
            rx_st       <= asp_pkg::ASP_START;
            rx_ph       <= 4'h1;
            rx_stop_bad <= 1'b0;
            rx_par_bad  <= 1'b0;
          end
        end
        asp_pkg::ASP_START:
          if (rx_decided) begin
            if (vote({rx_smp[1:0], rx_line}))
              rx_st <= asp_pkg::ASP_IDLE; // glitch, not a start
            else begin
              rx_st  <= asp_pkg::ASP_DATA;
              rx_bit <= 3'h0;
            end
          end
        asp_pkg::ASP_DATA:
          if (rx_decided) begin
            rx_sh  <= {vote({rx_smp[1:0], rx_line}), rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7)
              rx_st <= ctl1[asp_pkg::CTL1_PE] ? asp_pkg::ASP_PAR
                                              : asp_pkg::ASP_STOP1;
          end
        asp_pkg::ASP_PAR:
          if (rx_decided) begin
            // parity check, even sets xor to zero
            rx_par_bad <= (^rx_sh ^ vote({rx_smp[1:0], rx_line}))
                          != ~ctl1[asp_pkg::CTL1_EVEN];
            rx_st <= asp_pkg::ASP_STOP1;
          end
        asp_pkg::ASP_STOP1:
          if (rx_decided) begin
            rx_stop_bad <= ~vote({rx_smp[1:0], rx_line});
            if (receive_stop_length)
              rx_st <= asp_pkg::ASP_STOP2;
            else begin
              rx_st   <= asp_pkg::ASP_IDLE;
              rx_done <= 1'b1;
            end
          end
        asp_pkg::ASP_STOP2:
          if (rx_decided) begin
            rx_stop_bad <= rx_stop_bad | ~vote({rx_smp[1:0], rx_line});
            rx_st       <= asp_pkg::ASP_IDLE;
            rx_done     <= 1'b1;
          end
        default: rx_st <= asp_pkg::ASP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive flags; hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_seen_rx <= 1'b0;
      ovr_at_stat  <= 1'b0;
    end else if (rd_stat) begin
      stat_seen_rx <= 1'b1;
      ovr_at_stat  <= overrun_flag;
    end else if (rd_buf)
      stat_seen_rx <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      parity_error_flag      <= 1'b0;
      framing_error_flag     <= 1'b0;
      overrun_flag           <= 1'b0;
      receive_full_flag      <= 1'b0;
      receive_holding_buffer <= asp_pkg::BUF_RST;
      receive_interrupt_o    <= 1'b0;
    end else begin
      receive_interrupt_o <= 1'b0;
      // clear on status then buffer read
      if (rd_buf & stat_seen_rx) begin
        parity_error_flag  <= 1'b0;
        framing_error_flag <= 1'b0;
        receive_full_flag  <= 1'b0;
        if (ovr_at_stat)
          overrun_flag <= 1'b0;
      end
      if (rx_done) begin
        if (receive_full_flag & ~(rd_buf & stat_seen_rx))
          overrun_flag <= 1'b1;
        else begin
          receive_holding_buffer <= rx_sh;
          receive_full_flag      <= 1'b1;
          receive_interrupt_o    <= 1'b1;
          if (rx_par_bad)
            parity_error_flag <= 1'b1;
          if (rx_stop_bad)
            framing_error_flag <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer write; refused without prior status read
  always_ff @(posedge clk_i) begin
    if (rst_i)
      stat_seen_tx <= 1'b0;
    else if (rd_stat)
      stat_seen_tx <= 1'b1;
    else if (wr_buf)
      stat_seen_tx <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_holding_buffer <= asp_pkg::BUF_RST;
      tx_pending              <= 1'b0;
    end else begin
      if (wr_buf & stat_seen_tx) begin
        transmit_holding_buffer <= req.dat;
        tx_pending              <= 1'b1;
      end else if (tx_st == asp_pkg::ASP_IDLE & tick & tx_pending &
                   ctl1[asp_pkg::CTL1_TXE])
        tx_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter: bit period is sixteen ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st                <= asp_pkg::ASP_IDLE;
      tx_ph                <= 4'h0;
      tx_bit               <= 3'h0;
      tx_sh                <= 8'h00;
      tx_par               <= 1'b0;
      tx_line              <= 1'b1;
      transmit_empty_flag  <= 1'b1;
      transmit_end_flag    <= 1'b1;
      transmit_interrupt_o <= 1'b0;
    end else begin
      transmit_interrupt_o <= 1'b0;
      if (wr_buf & stat_seen_tx)
        transmit_empty_flag <= 1'b0;
      if (tick)
        tx_ph <= tx_ph + 4'h1;
      case (tx_st)
        asp_pkg::ASP_IDLE: begin
          tx_line <= 1'b1;
          tx_ph   <= 4'h0;
          if (tick & tx_pending & ctl1[asp_pkg::CTL1_TXE]) begin
            tx_sh                <= transmit_holding_buffer;
            tx_par               <= ^transmit_holding_buffer ^
                                    ~ctl1[asp_pkg::CTL1_EVEN];
            transmit_empty_flag  <= 1'b1;
            transmit_interrupt_o <= 1'b1;
            transmit_end_flag    <= 1'b0;
            tx_line <= 1'b0;
            tx_st   <= asp_pkg::ASP_START;
          end
        end
        asp_pkg::ASP_START:
          if (tick & tx_ph == asp_pkg::PHASES_MAX) begin
            tx_st   <= asp_pkg::ASP_DATA;
            tx_bit  <= 3'h0;
            tx_line <= tx_sh[0];
          end
        asp_pkg::ASP_DATA:
          if (tick & tx_ph == asp_pkg::PHASES_MAX) begin
            tx_sh  <= {1'b0, tx_sh[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit != 3'h7)
              tx_line <= tx_sh[1];
            else if (ctl1[asp_pkg::CTL1_PE]) begin
              tx_line <= tx_par;
              tx_st   <= asp_pkg::ASP_PAR;
            end else begin
              tx_line <= 1'b1;
              tx_st   <= asp_pkg::ASP_STOP1;
            end
          end
        asp_pkg::ASP_PAR:
          if (tick & tx_ph == asp_pkg::PHASES_MAX) begin
            tx_line <= 1'b1;
            tx_st   <= asp_pkg::ASP_STOP1;
          end
        asp_pkg::ASP_STOP1:
          if (tick & tx_ph == asp_pkg::PHASES_MAX) begin
            if (ctl1[asp_pkg::CTL1_TRANSMIT_STOP_LENGTH])
              tx_st <= asp_pkg::ASP_STOP2;
            else begin
              tx_st             <= asp_pkg::ASP_IDLE;
              transmit_end_flag <= ~tx_pending;
            end
          end
        asp_pkg::ASP_STOP2:
          if (tick & tx_ph == asp_pkg::PHASES_MAX) begin
            tx_st             <= asp_pkg::ASP_IDLE;
            transmit_end_flag <= ~tx_pending;
          end
        default: tx_st <= asp_pkg::ASP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output pins, unselected pin stays at idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_pin_a_o <= 1'b1;
      transmit_pin_b_o <= 1'b1;
    end else begin
      transmit_pin_a_o <= pin_route_select[asp_pkg::SEL_TX] ? 1'b1 : tx_line;
      transmit_pin_b_o <= pin_route_select[asp_pkg::SEL_TX] ? tx_line : 1'b1;
    end
  end

endmodule // asp_uart

//--- testbench/asp_uart_chk.sv
// checker: bus answer and serial pin timing of the serial port
`timescale 1ns/100ps
module asp_uart_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone side
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [17:0] adr_i,
  input wire logic [7:0]  dat_i,
  input wire logic [7:0]  dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // timer, interrupts and pins
  input wire logic        timer_four_event_i,
  input wire logic        transmit_interrupt_o,
  input wire logic        receive_interrupt_o,
  input wire logic        receive_pin_a_i,
  input wire logic        receive_pin_b_i,
  input wire logic        transmit_pin_a_o,
  input wire logic        transmit_pin_b_o
);
  logic mapped;
  logic req;
  // request taken only while no answer is pending
  assign mapped = adr_i[17:2] >= asp_pkg::SEL_IDX &&
                  adr_i[17:2] <= asp_pkg::TMR_IDX;
  assign req    = cyc_i && stb_i && !ack_o && !err_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_map;   req && mapped |=> ack_o && !err_o;   endproperty
  property p_err_unmap; req && !mapped |=> err_o && !ack_o;  endproperty
  property p_ack_pulse; ack_o || err_o |=> !ack_o && !err_o; endproperty
  property p_pin_pair;  transmit_pin_a_o || transmit_pin_b_o; endproperty
  property p_reset_idle;
    $fell(rst_i) |-> transmit_pin_a_o && transmit_pin_b_o &&
      !transmit_interrupt_o && !receive_interrupt_o;
  endproperty
  property p_txi_start;
    transmit_interrupt_o |-> ##[0:2] !(transmit_pin_a_o && transmit_pin_b_o);
  endproperty
  // a bit lasts sixteen ticks; pin a is only checked low for eight clocks
  property p_start_len;
    $fell(transmit_pin_a_o) |-> !transmit_pin_a_o [*8];
  endproperty
  property p_txi_gap; transmit_interrupt_o |=> !transmit_interrupt_o [*8];
  endproperty
  property p_rxi_gap; receive_interrupt_o |=> !receive_interrupt_o [*8];
  endproperty
  a_ack_map:    assert property (p_ack_map)    else $error("no ack");
  a_err_unmap:  assert property (p_err_unmap)  else $error("no err");
  a_ack_pulse:  assert property (p_ack_pulse)  else $error("long ack");
  a_pin_pair:   assert property (p_pin_pair)   else $error("pins");
  a_reset_idle: assert property (p_reset_idle) else $error("idle");
  a_txi_start:  assert property (p_txi_start)  else $error("start");
  a_start_len:  assert property (p_start_len)  else $error("short");
  a_txi_gap:    assert property (p_txi_gap)    else $error("txi");
  a_rxi_gap:    assert property (p_rxi_gap)    else $error("rxi");
  c_err: cover property (err_o);
  c_txi: cover property (transmit_interrupt_o);
  c_rxi: cover property (receive_interrupt_o);
  c_pin_b: cover property (!transmit_pin_b_o);
endmodule // asp_uart_chk
////////////////////////////////////////////////////////////////////////////
bind asp_uart asp_uart_chk asp_uart_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .timer_four_event_i(timer_four_event_i),
  .transmit_interrupt_o(transmit_interrupt_o),
  .receive_interrupt_o(receive_interrupt_o),
  .receive_pin_a_i(receive_pin_a_i), .receive_pin_b_i(receive_pin_b_i),
  .transmit_pin_a_o(transmit_pin_a_o), .transmit_pin_b_o(transmit_pin_b_o));

//--- testbench/asp_peer.sv
// remote serial peer: sends frames on the line and decodes received ones
`timescale 1ns/100ps
module asp_peer (
  // clock and lines
  input  wire logic clk_i,
  input  wire logic tx_line_i,
  output logic      rx_line_o
);
  int bit_clks = 208;
  initial rx_line_o = 1'b1;
  // one frame out; stop level is a knob for framing faults
  // frame, lsb first
  task automatic send(input logic [7:0] d, input logic pe, input logic pb,
                      input logic stopv);
    logic [10:0] f;
    f = {stopv, pb, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || pe) begin
        rx_line_o <= (i == 10 || i == 9) && !pe && i == 9 ? stopv : f[i];
        repeat (bit_clks) @(posedge clk_i);
      end
    end
    rx_line_o <= 1'b1;
    repeat (bit_clks) @(posedge clk_i);
  endtask
  // decode one frame, sampled mid-bit; ok low on timeout or bad stop
  task automatic recv(input logic pe, input logic two, output logic [7:0] d,
                      output logic pb, output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 4000 && tx_line_i; n++) @(posedge clk_i);
    if (n < 4000) begin
      ok = 1'b1;
      repeat (bit_clks / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        d[i] = tx_line_i;
      end
      pb = 1'b0;
      if (pe) begin
        repeat (bit_clks) @(posedge clk_i);
        pb = tx_line_i;
      end
      for (int i = 0; i <= two; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        ok = ok && tx_line_i;
      end
    end
  endtask
endmodule // asp_peer

//--- testbench/asp_uart_bench.sv
// bench: register access, transmit and receive frames of the serial port
`timescale 1ns/100ps
module asp_uart_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, tmr = 1'b0, ack, err, txi, rxi, tpa, tpb;
  logic [17:0] adr = 18'h00000;
  logic [7:0]  wd = 8'h00, rd, q, d, g;
  logic [1:0]  sel = 2'h0;
  logic        line, pb, ok, pe, ev, two, e, tfull = 1'b0;
  logic [2:0]  bd;
  int          bad_count = 0, n_tests = 0, tick = 0, seed = 32'h8E6A2435;
  always #25 clk_i = ~clk_i;
  // unselected receive pin toggles so a wrong route shows at once
  always @(posedge clk_i) begin
    tick <= tick + 1;
    tmr  <= tfull | 1'($random(seed));
  end
  asp_uart asp_uart_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wd), .dat_o(rd),
    .ack_o(ack), .err_o(err), .timer_four_event_i(tmr),
    .transmit_interrupt_o(txi), .receive_interrupt_o(rxi),
    .receive_pin_a_i(sel[0] ? tick[0] : line),
    .receive_pin_b_i(sel[0] ? line : tick[0]),
    .transmit_pin_a_o(tpa), .transmit_pin_b_o(tpb));
  asp_peer asp_peer_inst (.clk_i(clk_i), .tx_line_i(sel[1] ? tpb : tpa),
    .rx_line_o(line));
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] y);
    n_tests++;
    if (y !== x) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, x, y);
    end
  endtask
  // one classic cycle, held until ack or err is sampled high
  task automatic wb(input logic w, input logic [15:0] ix, input logic [7:0] v,
                    output logic [7:0] r, output logic er);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {ix, 2'b00};
    wd  <= v;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    if (n == 50) chk("bus answer", 8'h01, 8'h00);
    r = rd;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [15:0] ix,
                       input logic [7:0] x);
    wb(1'b0, ix, 8'h00, q, e);
    chk(nm, x, q);
  endtask
  function automatic logic par(input logic [7:0] v, input logic even);
    par = even ? ^v : ~^v;
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #5_000_000;
    bad_count++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("status reset", asp_pkg::STAT_IDX, 8'h0C);
    wb(1'b0, 16'h1F96, 8'h00, q, e);
    chk("unmapped err", 8'h01, {7'h00, e});
    for (int r = 0; r < 3; r++) begin
      {pe, ev, two} = $random(seed);
      // last round runs from a timer event on every clock
      tfull = (r == 2);
      bd    = (r == 2) ? asp_pkg::BRG_TMR4 : 3'h0;
      // route and timer compare set while both directions are off, baud code with the enables
      // host order
      wb(1'b1, asp_pkg::CTL1_IDX, 8'h00, q, e);
      // swap pins only with the receiver off, the toggling pin could start
      sel = (r == 0) ? 2'h0 : 2'($random(seed));
      wb(1'b1, asp_pkg::SEL_IDX, {6'h00, sel}, q, e);
      rdchk("route", asp_pkg::SEL_IDX, {6'h00, sel});
      // receive stop length follows the transmit one
      wb(1'b1, asp_pkg::CTL2_IDX, {7'h00, two}, q, e);
      // thirteen events per phase keep the code 0 bit time
      wb(1'b1, asp_pkg::TMR_IDX, 8'h0D, q, e);
      wb(1'b1, asp_pkg::CTL1_IDX, {2'b11, two, ev, pe, bd}, q, e);
      d = $random(seed);
      rdchk("status idle", asp_pkg::STAT_IDX, 8'h0C);
      wb(1'b1, asp_pkg::BUF_IDX, d, q, e);
      wb(1'b1, asp_pkg::BUF_IDX, ~d, q, e);
      asp_peer_inst.recv(pe, two, g, pb, ok);
      chk("tx byte", d, g);
      chk("tx frame", {7'h00, 1'b1}, {7'h00, ok});
      chk("tx parity", {7'h00, pe & par(d, ev)}, {7'h00, pb});
      repeat (600) @(posedge clk_i);
      rdchk("tx end", asp_pkg::STAT_IDX, 8'h0C);
      // good, wrong parity, low stop
      for (int k = 0; k < 3; k++) begin
        d = $random(seed);
        fork
          asp_peer_inst.send(d, pe, par(d, ev) ^ (k == 1), k != 2);
          for (int n = 0; n < 4000 && rxi !== 1'b1; n++) @(posedge clk_i);
        join
        rdchk("rx status", asp_pkg::STAT_IDX,
              {k == 1 && pe, k == 2, 2'b01, 4'hC});
        rdchk("rx byte", asp_pkg::BUF_IDX, d);
        rdchk("rx clear", asp_pkg::STAT_IDX, 8'h0C);
      end
      g = $random(seed);
      d = $random(seed);
      asp_peer_inst.send(g, pe, par(g, ev), 1'b1);
      asp_peer_inst.send(d, pe, par(d, ev), 1'b1);
      rdchk("overrun status", asp_pkg::STAT_IDX, 8'h3C);
      rdchk("overrun keep", asp_pkg::BUF_IDX, g);
      rdchk("overrun clear", asp_pkg::STAT_IDX, 8'h0C);
      // overrun landing between status read and buffer read
      asp_peer_inst.send(g, pe, par(g, ev), 1'b1);
      rdchk("late status", asp_pkg::STAT_IDX, 8'h1C);
      asp_peer_inst.send(d, pe, par(d, ev), 1'b1);
      rdchk("late byte", asp_pkg::BUF_IDX, g);
      // buffer now empty but overrun set, so this frame is ignored
      asp_peer_inst.send(~g, pe, par(~g, ev), 1'b1);
      rdchk("late overrun", asp_pkg::STAT_IDX, 8'h2C);
      rdchk("late clear", asp_pkg::BUF_IDX, g);
      rdchk("after late", asp_pkg::STAT_IDX, 8'h0C);
      $display("test round %0d done", r);
    end
    final_report;
  end
endmodule // asp_uart_bench
